// ---- logic/tcp_timer.sv ----
// tcp_timer.sv - 16-bit timer with capture, compare, edge and center pwm channels
// assumes byte register port on clk; pins and clock inputs asynchronous to clk
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "tcp_consts.svh"

module tcp_timer #(
  parameter int NCH = 2
) (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic [5:0]     addr,
  input  wire logic [7:0]     wdata,
  input  wire logic           wr,
  input  wire logic           rd,
  output logic      [7:0]     rdata,
  input  wire logic           bdm_active,
  input  wire logic           fixed_clk_in,
  input  wire logic           ext_clk_in,
  input  wire logic [NCH-1:0] chan_pin_in,
  output logic      [NCH-1:0] chan_pin_out,
  output logic      [NCH-1:0] chan_pin_oe,
  input  wire logic [1:0]     alt_pin_in,
  output logic      [1:0]     alt_pin_out,
  output logic      [1:0]     alt_pin_oe,
  output logic                irq
);
  // control and counter state
  logic        tof_reg, toie_reg, center_align_select_reg, pos_reg;
  logic [1:0]  clock_source_select_reg;
  logic [2:0]  ps_reg;
  logic [6:0]  pre_reg, pre_next;
  logic [15:0] cnt_reg, cnt_next, mod_reg;
  logic [7:0]  mod_hi_reg;
  logic        mod_pend_reg, down_reg, down_next, step_reg;
  logic        fix_prev_reg, ext_prev_reg;

  // synchronised pins
  logic [NCH+3:0] sync_q;
  wire logic [NCH-1:0] chan_s = sync_q[NCH-1:0];
  wire logic [1:0]     alt_s  = sync_q[NCH+1:NCH];
  wire logic           ext_s  = sync_q[NCH+2];
  wire logic           fix_s  = sync_q[NCH+3];

  tcp_sync #(
    .W(NCH + 4)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d  ({fixed_clk_in, ext_clk_in, alt_pin_in, chan_pin_in}),
    .q  (sync_q)
  );

  // register decode
  wire logic       wr_sc   = wr & (addr == `TCP_A_SC);
  wire logic       cnt_wr  = wr & ((addr == `TCP_A_CNTH) | (addr == `TCP_A_CNTL));
  wire logic       wr_modh = wr & (addr == `TCP_A_MODH);
  wire logic       wr_modl = wr & (addr == `TCP_A_MODL);
  wire logic       wr_opt  = wr & (addr == `TCP_A_OPT);
  wire logic [2:0] ch_idx  = addr[4:2];
  wire logic       ch_hit  = addr[5] & (32'(ch_idx) < NCH);

  // clock source and prescaler
  wire logic fix_rise = fix_s & ~fix_prev_reg;
  wire logic ext_rise = ext_s & ~ext_prev_reg;
  wire logic src_pulse = (clock_source_select_reg == `TCP_CLK_BUS) ? 1'h1 :
                         (clock_source_select_reg == `TCP_CLK_FIX) ? fix_rise :
                         (clock_source_select_reg == `TCP_CLK_EXT) ? ext_rise :
                         1'h0;
  wire logic       run      = src_pulse & ~bdm_active;
  wire logic [6:0] ps_mask  = ~(7'h7f << ps_reg);
  wire logic       cnt_tick = run & ((pre_reg & ps_mask) == ps_mask);

  // counter limits
  wire logic mod_free = (mod_reg == `TCP_CNT_ZERO) | (mod_reg == `TCP_CNT_MAX);
  wire logic [15:0] top_w = mod_free ? `TCP_CNT_MAX : mod_reg;
  wire logic at_top  = (cnt_reg >= top_w);
  wire logic at_zero = (cnt_reg == `TCP_CNT_ZERO);
  wire logic tof_set = cnt_tick & at_top & (~center_align_select_reg | ~down_reg);
  wire logic pwm_load = step_reg & (cnt_reg == top_w) & ~down_reg;

  always_comb begin
    pre_next = pre_reg;
    if (cnt_wr)
      pre_next = 7'h00;
    else if (run)
      pre_next = 7'(pre_reg + 7'h01);
  end

  always_comb begin
    cnt_next  = cnt_reg;
    down_next = down_reg;
    if (cnt_wr) begin
      cnt_next  = `TCP_CNT_ZERO;
      down_next = 1'h0;
    end else if (cnt_tick) begin
      if (~center_align_select_reg) begin
        cnt_next  = at_top ? `TCP_CNT_ZERO : 16'(cnt_reg + `TCP_CNT_ONE);
        down_next = 1'h0;
      end else if (~down_reg) begin
        cnt_next  = at_top ? 16'(cnt_reg - `TCP_CNT_ONE)
                           : 16'(cnt_reg + `TCP_CNT_ONE);
        down_next = at_top;
      end else begin
        cnt_next  = at_zero ? 16'(cnt_reg + `TCP_CNT_ONE)
                            : 16'(cnt_reg - `TCP_CNT_ONE);
        down_next = ~at_zero;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_reg      <= 7'h00;
      cnt_reg      <= `TCP_CNT_ZERO;
      down_reg     <= 1'h0;
      step_reg     <= 1'h0;
      fix_prev_reg <= 1'h0;
      ext_prev_reg <= 1'h0;
    end else begin
      pre_reg      <= pre_next;
      cnt_reg      <= cnt_next;
      down_reg     <= down_next;
      step_reg     <= cnt_tick & ~cnt_wr;
      fix_prev_reg <= fix_s;
      ext_prev_reg <= ext_s;
    end
  end

  // module status and control, modulo pair, options
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tof_reg      <= 1'h0;
      toie_reg     <= 1'h0;
      center_align_select_reg    <= 1'h0;
      clock_source_select_reg     <= `TCP_CLK_OFF;
      ps_reg       <= 3'h0;
      mod_reg      <= `TCP_CNT_ZERO;
      mod_hi_reg   <= `TCP_BYTE_0;
      mod_pend_reg <= 1'h0;
      pos_reg      <= 1'h0;
    end else begin
      tof_reg <= tof_set | (tof_reg & ~(wr_sc & ~wdata[`TCP_SC_TOF]));
      if (wr_sc) begin
        toie_reg  <= wdata[`TCP_SC_TOIE];
        center_align_select_reg <= wdata[`TCP_SC_CENTER_ALIGN_SELECT];
        clock_source_select_reg  <= wdata[`TCP_SC_CLOCK_SOURCE_SELECT];
        ps_reg    <= wdata[`TCP_SC_PS];
      end
      if (wr_modh)
        mod_hi_reg <= wdata;
      if (wr_modl & mod_pend_reg)
        mod_reg <= {mod_hi_reg, wdata};
      mod_pend_reg <= ~wr_sc & (wr_modh | (mod_pend_reg & ~wr_modl));
      if (wr_opt)
        pos_reg <= wdata[`TCP_OPT_POS];
    end
  end

  // channels
  logic [7:0][15:0] ch_val_all;
  logic [7:0][7:0]  ch_sc_all;
  logic [7:0]       ch_pin_w, ch_oe_w, ch_irq_w;
  wire logic [7:0]  pin_s8 = 8'(chan_s);
  wire logic [7:0]  ch_in_all = pos_reg ? {pin_s8[7:2], alt_s} : pin_s8;

  for (genvar i = 0; i < 8; i++) begin : g_ch
    if (i < NCH) begin : g_on
      logic                  flag_reg, ie_reg, flag_set_w;
      logic [1:0]            ms_reg, els_reg;
      tcp_pkg::tcp_mode_type ch_mode;
      wire logic wr_ch = wr & addr[5] & (ch_idx == 3'(i));
      wire logic wr_cs = wr_ch & (addr[1:0] == `TCP_CH_SC);

      assign ch_mode = (clock_source_select_reg == `TCP_CLK_OFF) ? tcp_pkg::TCP_MODE_OFF  :
                       center_align_select_reg                  ? tcp_pkg::TCP_MODE_CENTER_ALIGNED_PWM :
                       (ms_reg == `TCP_MS_CAP)    ? tcp_pkg::TCP_MODE_CAP  :
                       (ms_reg == `TCP_MS_CMP)    ? tcp_pkg::TCP_MODE_CMP  :
                       tcp_pkg::TCP_MODE_EDGE_ALIGNED_PWM;

      tcp_chan u_chan (
        .clk     (clk),
        .rst     (rst),
        .mode    (ch_mode),
        .els     (els_reg),
        .cnt     (cnt_reg),
        .step    (step_reg),
        .down    (down_reg),
        .pwm_load(pwm_load),
        .wr_hi   (wr_ch & (addr[1:0] == `TCP_CH_VH)),
        .wr_lo   (wr_ch & (addr[1:0] == `TCP_CH_VL)),
        .coh_clr (wr_sc),
        .wdata   (wdata),
        .pin_in  (ch_in_all[i]),
        .val     (ch_val_all[i]),
        .flag_set(flag_set_w),
        .pin_out (ch_pin_w[i]),
        .pin_oe  (ch_oe_w[i])
      );

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flag_reg <= 1'h0;
          ie_reg   <= 1'h0;
          ms_reg   <= `TCP_MS_CAP;
          els_reg  <= `TCP_ELS_NONE;
        end else begin
          flag_reg <= flag_set_w | (flag_reg & ~(wr_cs & ~wdata[`TCP_CS_FLAG]));
          if (wr_cs) begin
            ie_reg  <= wdata[`TCP_CS_IE];
            ms_reg  <= wdata[`TCP_CS_MS];
            els_reg <= wdata[`TCP_CS_ELS];
          end
        end
      end

      assign ch_sc_all[i] = {flag_reg, ie_reg, ms_reg, els_reg, 2'h0};
      assign ch_irq_w[i]  = flag_reg & ie_reg;
    end else begin : g_off
      assign ch_val_all[i] = `TCP_CNT_ZERO;
      assign ch_sc_all[i]  = `TCP_BYTE_0;
      assign ch_pin_w[i]   = 1'h0;
      assign ch_oe_w[i]    = 1'h0;
      assign ch_irq_w[i]   = 1'h0;
    end
  end

  // pin routing and read data
  wire logic [7:0] def_oe_w = ch_oe_w & ~(`TCP_ALT_MASK & {8{pos_reg}});
  wire logic [1:0] alt_oe_w = ch_oe_w[1:0] & {2{pos_reg}};
  wire logic [7:0] sc_byte  = {tof_reg, toie_reg, center_align_select_reg, clock_source_select_reg, ps_reg};
  wire logic [15:0] sel_val = ch_val_all[ch_idx];
  wire logic [7:0] rd_mux =
    (addr == `TCP_A_SC)   ? sc_byte :
    (addr == `TCP_A_CNTH) ? cnt_reg[15:8] :
    (addr == `TCP_A_CNTL) ? cnt_reg[7:0] :
    (addr == `TCP_A_MODH) ? mod_reg[15:8] :
    (addr == `TCP_A_MODL) ? mod_reg[7:0] :
    (addr == `TCP_A_OPT)  ? {7'h00, pos_reg} :
    (ch_hit && (addr[1:0] == `TCP_CH_SC)) ? ch_sc_all[ch_idx] :
    (ch_hit && (addr[1:0] == `TCP_CH_VH)) ? sel_val[15:8] :
    (ch_hit && (addr[1:0] == `TCP_CH_VL)) ? sel_val[7:0] :
    `TCP_BYTE_0;
  wire logic irq_w = (tof_reg & toie_reg) | (|ch_irq_w);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata        <= `TCP_BYTE_0;
      irq          <= 1'h0;
      chan_pin_out <= '0;
      chan_pin_oe  <= '0;
      alt_pin_out  <= 2'h0;
      alt_pin_oe   <= 2'h0;
    end else begin
      rdata        <= rd ? rd_mux : `TCP_BYTE_0;
      irq          <= irq_w;
      chan_pin_out <= ch_pin_w[NCH-1:0];
      chan_pin_oe  <= def_oe_w[NCH-1:0];
      alt_pin_out  <= ch_pin_w[1:0];
      alt_pin_oe   <= alt_oe_w;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_cnt_write_clears;
    cnt_wr |=> (cnt_reg == `TCP_CNT_ZERO) && !down_reg;
  endproperty
  a_cnt_write_clears: assert property (p_cnt_write_clears)
    else $error("counter not cleared by write");

  property p_debug_halts;
    bdm_active && !cnt_wr |=> $stable(cnt_reg);
  endproperty
  a_debug_halts: assert property (p_debug_halts)
    else $error("counter moved in debug mode");

  property p_wrap_sets_tof;
    cnt_tick && !cnt_wr && !center_align_select_reg && at_top |=> tof_reg && (cnt_reg == 16'h0000);
  endproperty
  a_wrap_sets_tof: assert property (p_wrap_sets_tof)
    else $error("wrap did not clear counter and set flag");

  property p_free_run_full;
    cnt_tick && !cnt_wr && !center_align_select_reg && mod_free && (cnt_reg == 16'hfffe)
      |-> !tof_set ##1 (cnt_reg == 16'hffff);
  endproperty
  a_free_run_full: assert property (p_free_run_full)
    else $error("free running counter skipped full range");

  property p_up_count;
    cnt_tick && !cnt_wr && !center_align_select_reg && !at_top |=> cnt_reg == $past(cnt_reg) + 16'h0001;
  endproperty
  a_up_count: assert property (p_up_count)
    else $error("counter did not advance by one");

  sequence s_at_top_up;
    cnt_tick && !cnt_wr && center_align_select_reg && !down_reg && at_top;
  endsequence
  sequence s_turned_down;
    down_reg && (cnt_reg == $past(cnt_reg) - 16'h0001);
  endsequence
  property p_center_turn;
    s_at_top_up |=> s_turned_down;
  endproperty
  a_center_turn: assert property (p_center_turn)
    else $error("center mode did not turn down at top");

  property p_bus_div1_ticks;
    (clock_source_select_reg == 2'h1) && (ps_reg == 3'h0) && !bdm_active |-> cnt_tick;
  endproperty
  a_bus_div1_ticks: assert property (p_bus_div1_ticks)
    else $error("divide by one missed a tick");

  property p_ext_only_on_edge;
    cnt_tick && (clock_source_select_reg == 2'h3) |-> ext_s && !ext_prev_reg;
  endproperty
  a_ext_only_on_edge: assert property (p_ext_only_on_edge)
    else $error("external source ticked without edge");

  property p_irq_follows;
    (tof_reg && toie_reg) |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt not raised for enabled flag");

  property p_read_no_disturb;
    rd && !bdm_active && !cnt_wr && !cnt_tick |=> $stable(cnt_reg);
  endproperty
  a_read_no_disturb: assert property (p_read_no_disturb)
    else $error("read disturbed counter");
endmodule

`default_nettype wire

// ---- logic/tcp_consts.svh ----
// tcp_consts.svh - register map, field positions and codes of the timer block
// assumes inclusion by every timer source file; definitions only
// Overview of operation
// - channel value writes direct only in capture or with clock off
// - pwm value loads when counter reaches top
// - control write clears byte-pair coherency state
// - clock select 1:1 picks external clock pin
// - position bit moves channels 0,1 to alternates
// - prescaler divides by 1 to 128
// - bus, fixed or external source; fixed synchronised
// - 16-bit counter, free, modulo up or up-down
// - one flag per channel plus terminal count
// - center-align bit forces all channels center pwm
// - debug mode halts all counting
// - runs in wait; stops with clocks
// - capture copies counter on chosen edge, flags
// - compare match flags and clears, sets, toggles
// - edge pwm period modulo plus one, polarity
// - center pwm counts up then down
// - modulo 0x0000 or 0xffff means free running
// - counter reads never disturb counting
// - any counter byte write clears counter
// - one to eight channels, one pin each
// - high-true edge pwm: high at zero, low match
// - center pwm: clear up-match, set down-match
// - toggle mode keeps old level until match
// - capture pins pass synchroniser before edge detect
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH

`define TCP_A_SC     6'h00
`define TCP_A_CNTH   6'h01
`define TCP_A_CNTL   6'h02
`define TCP_A_MODH   6'h03
`define TCP_A_MODL   6'h04
`define TCP_A_OPT    6'h05
`define TCP_CH_SC    2'h0
`define TCP_CH_VH    2'h1
`define TCP_CH_VL    2'h2

`define TCP_SC_TOF   7
`define TCP_SC_TOIE  6
`define TCP_SC_CENTER_ALIGN_SELECT 5
`define TCP_SC_CLOCK_SOURCE_SELECT  4:3
`define TCP_SC_PS    2:0
`define TCP_CS_FLAG  7
`define TCP_CS_IE    6
`define TCP_CS_MS    5:4
`define TCP_CS_ELS   3:2
`define TCP_OPT_POS  0

`define TCP_CLK_OFF  2'h0
`define TCP_CLK_BUS  2'h1
`define TCP_CLK_FIX  2'h2
`define TCP_CLK_EXT  2'h3
`define TCP_MS_CAP   2'h0
`define TCP_MS_CMP   2'h1
`define TCP_ELS_NONE 2'h0
`define TCP_OC_TOG   2'h1
`define TCP_OC_CLR   2'h2
`define TCP_OC_SET   2'h3
`define TCP_ALT_MASK 8'h03

`define TCP_CNT_ZERO 16'h0000
`define TCP_CNT_ONE  16'h0001
`define TCP_CNT_MAX  16'hffff
`define TCP_BYTE_0   8'h00

`endif

// ---- logic/tcp_pkg.sv ----
// tcp_pkg.sv - types shared by the timer block
// assumes nothing beyond the constants header
package tcp_pkg;
  typedef enum logic [4:0] {
    TCP_MODE_OFF  = 5'h01,
    TCP_MODE_CAP  = 5'h02,
    TCP_MODE_CMP  = 5'h04,
    TCP_MODE_EDGE_ALIGNED_PWM = 5'h08,
    TCP_MODE_CENTER_ALIGNED_PWM = 5'h10
  } tcp_mode_type;
endpackage

// ---- logic/tcp_sync.sv ----
// tcp_sync.sv - two-stage synchroniser for pin levels
// assumes inputs asynchronous to clk
`timescale 1ns/10ps
`default_nettype none

module tcp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

`default_nettype wire

// ---- logic/tcp_chan.sv ----
// tcp_chan.sv - one timer channel: value register, capture, compare and pwm pin
// assumes counter, step strobe and synchronised pin from the timer top
`timescale 1ns/10ps
`default_nettype none
`include "tcp_consts.svh"

module tcp_chan (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire tcp_pkg::tcp_mode_type mode,
  input  wire logic [1:0]            els,
  input  wire logic [15:0]           cnt,
  input  wire logic                  step,
  input  wire logic                  down,
  input  wire logic                  pwm_load,
  input  wire logic                  wr_hi,
  input  wire logic                  wr_lo,
  input  wire logic                  coh_clr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  pin_in,
  output logic      [15:0]           val,
  output logic                       flag_set,
  output logic                       pin_out,
  output logic                       pin_oe
);
  logic [15:0] val_reg, val_next, buf_reg;
  logic        hi_pend_reg, load_pend_reg, prev_reg, pin_reg, pin_next;

  wire logic is_cap    = (mode == tcp_pkg::TCP_MODE_CAP);
  wire logic is_cmp    = (mode == tcp_pkg::TCP_MODE_CMP);
  wire logic is_out    = is_cmp | (mode == tcp_pkg::TCP_MODE_EDGE_ALIGNED_PWM)
                         | (mode == tcp_pkg::TCP_MODE_CENTER_ALIGNED_PWM);
  wire logic direct    = is_cap | (mode == tcp_pkg::TCP_MODE_OFF);
  wire logic pair_done = wr_lo & hi_pend_reg;
  wire logic match     = step & (cnt == val_reg);
  wire logic rise      = pin_in & ~prev_reg;
  wire logic fall      = ~pin_in & prev_reg;
  wire logic cap_evt   = is_cap & ((els[0] & rise) | (els[1] & fall));
  wire logic take      = is_cmp ? step : pwm_load;
  wire logic do_load   = load_pend_reg & ~direct & take;

  always_comb begin
    val_next = val_reg;
    if (cap_evt)
      val_next = cnt;
    else if (pair_done & direct)
      val_next = {buf_reg[15:8], wdata};
    else if (do_load)
      val_next = buf_reg;
  end

  always_comb begin
    pin_next = pin_reg;
    case (mode)
      tcp_pkg::TCP_MODE_CMP: begin
        if (match) begin
          case (els)
            `TCP_OC_TOG: pin_next = ~pin_reg;
            `TCP_OC_CLR: pin_next = 1'h0;
            `TCP_OC_SET: pin_next = 1'h1;
            default:     pin_next = pin_reg;
          endcase
        end
      end
      tcp_pkg::TCP_MODE_EDGE_ALIGNED_PWM: begin
        if (step & (cnt == `TCP_CNT_ZERO))
          pin_next = ~els[0];
        if (match)
          pin_next = els[0];
      end
      tcp_pkg::TCP_MODE_CENTER_ALIGNED_PWM: begin
        if (match)
          pin_next = down ? ~els[0] : els[0];
      end
      default: pin_next = pin_reg;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      val_reg       <= `TCP_CNT_ZERO;
      buf_reg       <= `TCP_CNT_ZERO;
      hi_pend_reg   <= 1'h0;
      load_pend_reg <= 1'h0;
      prev_reg      <= 1'h0;
      pin_reg       <= 1'h0;
    end else begin
      val_reg       <= val_next;
      if (wr_hi)
        buf_reg[15:8] <= wdata;
      if (wr_lo)
        buf_reg[7:0] <= wdata;
      hi_pend_reg   <= ~coh_clr & (wr_hi | (hi_pend_reg & ~wr_lo));
      load_pend_reg <= ~coh_clr & ((pair_done & ~direct) | (load_pend_reg & ~do_load));
      prev_reg      <= pin_in;
      pin_reg       <= pin_next;
    end
  end

  assign val      = val_reg;
  assign flag_set = cap_evt | (match & is_out);
  assign pin_out  = pin_reg;
  assign pin_oe   = is_out & (els != `TCP_ELS_NONE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_capture_copies;
    cap_evt |=> (val_reg == $past(cnt));
  endproperty
  a_capture_copies: assert property (p_capture_copies)
    else $error("capture did not copy the counter");

  property p_edge_aligned_pwm_low_on_match;
    (mode == tcp_pkg::TCP_MODE_EDGE_ALIGNED_PWM) && match && (els == 2'h2) |=> !pin_reg;
  endproperty
  a_edge_aligned_pwm_low_on_match: assert property (p_edge_aligned_pwm_low_on_match)
    else $error("high-true pwm pin not low after match");

  property p_pwm_no_direct_write;
    !direct && pair_done && !do_load && !cap_evt |=> $stable(val_reg);
  endproperty
  a_pwm_no_direct_write: assert property (p_pwm_no_direct_write)
    else $error("value written directly outside capture");
endmodule

`default_nettype wire

// ---- dv/tcp_pins_model.sv ----
// tcp_pins_model.sv - far side of the timer: channel pins and clock sources
// assumes the bench gives the level of undriven pins and frames the external clock
`timescale 1ns/10ps
`default_nettype none

module tcp_pins_model (
  input  wire logic       clk,
  input  wire logic       drv,
  input  wire logic       ext_run,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  input  wire logic [1:0] alt_out,
  input  wire logic [1:0] alt_oe,
  output logic      [1:0] pin_in,
  output logic      [1:0] alt_in,
  output logic            ext_clk,
  output logic            fix_clk
);
  logic [2:0] ph  = 3'h0;
  logic [2:0] fph = 3'h0;
  // wire level: block drive wins, else the far-side level
  assign pin_in  = (pin_oe & pin_out) | (~pin_oe & {2{drv}});
  assign alt_in  = (alt_oe & alt_out) | (~alt_oe & {2{drv}});
  // external clock at clk/8, stands low between frames
  assign ext_clk = ext_run & ~ph[2];
  // fixed clock runs free at clk/8
  assign fix_clk = fph[2];
  always @(posedge clk) begin
    ph  <= ext_run ? ph + 3'h1 : 3'h0;
    fph <= fph + 3'h1;
  end
endmodule

`default_nettype wire

// ---- dv/tb_top.sv ----
// tb_top.sv - self-checking bench of the timer block
// assumes two channels and the pin model on the far side
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [5:0]  addr = 6'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        background_debug_mode = 1'h1;
  logic        drv = 1'h0;
  logic        ext_run = 1'h0;
  logic [7:0]  rdata, v8;
  logic        fix_clk, ext_clk, irq;
  logic [1:0]  pin_in, pin_out, pin_oe, alt_in, alt_out, alt_oe;
  logic [16:0] seed = 17'h1266e;
  logic [15:0] v16;
  int          n_errors = 0, tests_run = 0, cyc = 0, k, top;

  always #5 clk = ~clk;

  tcp_timer #(.NCH(2)) DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .bdm_active(background_debug_mode), .fixed_clk_in(fix_clk), .ext_clk_in(ext_clk),
    .chan_pin_in(pin_in), .chan_pin_out(pin_out), .chan_pin_oe(pin_oe), .alt_pin_in(alt_in),
    .alt_pin_out(alt_out), .alt_pin_oe(alt_oe), .irq(irq));

  tcp_pins_model pins (.clk(clk), .drv(drv), .ext_run(ext_run), .pin_out(pin_out),
    .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe), .pin_in(pin_in), .alt_in(alt_in),
    .ext_clk(ext_clk), .fix_clk(fix_clk));

  function automatic logic [16:0] nxt(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction

  // counter after n steps from zero, up wrap or up-down to top t
  function automatic logic [15:0] exp_cnt(input int n, input int t, input bit c);
    int v;
    bit dn;
    v = 0;
    dn = 1'h0;
    for (int i = 0; i < n; i++) begin
      if (dn) v--;
      else if (v == t && !c) v = 0;
      else v++;
      if (c && v == t) dn = 1'h1;
      if (v == 0) dn = 1'h0;
    end
    return 16'(v);
  endfunction

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask

  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    wr_reg(a, d[15:8]);
    wr_reg(a + 6'h01, d[7:0]);
  endtask

  task automatic rd16(input logic [5:0] a, output logic [15:0] d);
    rd_reg(a, d[15:8]);
    rd_reg(a + 6'h01, d[7:0]);
  endtask

  // lets the counter run for n clock edges, then halts it in debug
  task automatic run(input int n);
    @(posedge clk);
    background_debug_mode <= 1'h0;
    repeat (n) @(posedge clk);
    background_debug_mode <= 1'h1;
    repeat (4) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("Checks run %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    rd16(6'h03, v16);
    check(v16, 16'h0000);
    for (int ps = 0; ps < 8; ps++) begin
      seed = nxt(seed);
      wr_reg(6'h00, 8'h08 | 8'(ps));
      wr_reg(6'h02, seed[7:0]);
      run(256);
      rd16(6'h01, v16);
      check(v16, 16'(256 >> ps));
      run(256);
      rd16(6'h01, v16);
      check(v16, 16'(512 >> ps));
    end
    for (int j = 0; j < 6; j++) begin
      seed = nxt(seed);
      top = 2 + seed[2:0];
      k = (j == 0) ? top : 4 + seed[8:4];
      wr16(6'h03, 16'(top));
      for (int c = 0; c < 2; c++) begin
        wr_reg(6'h00, c ? 8'h68 : 8'h48);
        wr_reg(6'h01, seed[15:8]);
        run(k);
        rd16(6'h01, v16);
        check(v16, exp_cnt(k, top, c[0]));
        rd_reg(6'h00, v8);
        check(16'(v8[7]), 16'(k > top));
        check(16'(irq), 16'(k > top));
      end
    end
    wr16(6'h03, 16'hffff);
    wr_reg(6'h00, 8'h08); // control before channel values
    wr_reg(6'h01, 8'h00);
    k = 100 + seed[15:8];
    run(k);
    rd16(6'h01, v16);
    check(v16, 16'(k));
    wr_reg(6'h20, 8'h44);
    drv <= 1'h1;
    repeat (8) @(posedge clk);
    rd16(6'h21, v16);
    check(v16, 16'(k));
    rd_reg(6'h20, v8);
    check(16'(v8), 16'h00c4);
    check(16'(irq), 16'h0001);
    wr_reg(6'h21, 8'h12);
    wr_reg(6'h00, 8'h08);
    wr_reg(6'h22, 8'h34);
    rd16(6'h21, v16);
    check(v16, 16'(k));
    wr16(6'h21, 16'h1234);
    rd16(6'h21, v16);
    check(v16, 16'h1234);
    wr_reg(6'h05, 8'h01);
    wr_reg(6'h20, 8'h1c);
    wr16(6'h21, 16'h0005 + 16'(seed[3:0]));
    rd16(6'h21, v16);
    check(v16, 16'h1234);
    wr_reg(6'h01, 8'h00);
    run(24);
    check(16'({alt_oe[0], alt_out[0], pin_oe[0]}), 16'h0006);
    wr_reg(6'h20, 8'h14);
    repeat (3) @(posedge clk);
    check(16'(alt_out[0]), 16'h0001);
    wr_reg(6'h01, 8'h00);
    run(24);
    check(16'(alt_out[0]), 16'h0000);
    wr_reg(6'h00, 8'h18);
    wr_reg(6'h01, 8'h00);
    k = 3 + seed[3:0];
    background_debug_mode <= 1'h0;
    ext_run <= 1'h1;
    repeat (8 * k) @(posedge clk);
    ext_run <= 1'h0;
    repeat (6) @(posedge clk);
    background_debug_mode <= 1'h1;
    rd16(6'h01, v16);
    check(v16, 16'(k));
    // fixed source: one tick per eight clocks
    wr_reg(6'h00, 8'h10);
    wr_reg(6'h01, 8'h00);
    run(64);
    rd16(6'h01, v16);
    check(v16, 16'h0008);
    // edge pwm, high-true, modulo 8, new duty 3
    wr16(6'h03, 16'h0008);
    wr_reg(6'h00, 8'h08);
    wr_reg(6'h20, 8'h28);
    wr16(6'h21, 16'h0003);
    wr_reg(6'h01, 8'h00);
    rd16(6'h21, v16);
    check(v16, 16'h0005 + 16'(seed[3:0]));
    run(11);
    check(16'(alt_out[0]), 16'h0001);
    rd16(6'h21, v16);
    check(v16, 16'h0003);
    run(1);
    check(16'(alt_out[0]), 16'h0000);
    // center pwm: set on down match, clear on up match
    wr_reg(6'h00, 8'h28);
    wr_reg(6'h01, 8'h00);
    run(13);
    check(16'(alt_out[0]), 16'h0001);
    run(6);
    check(16'(alt_out[0]), 16'h0000);
    finish_test();
  end
endmodule

`default_nettype wire
